// [src/otp_store_pkg.sv]
/*
  Shared constants of the one-time-programmable parameter store: byte
  addresses, field positions, command codes and timing counts.
  Assumes a single 20 MHz core clock.
*/
package otp_store_pkg;
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned NUM_BYTES = 8;
  localparam logic [2:0] ADDR_TRIM_A = 3'h0;
  localparam logic [2:0] ADDR_TRIM_B = 3'h1;
  localparam logic [2:0] ADDR_THR_NODE = 3'h2;
  localparam logic [2:0] ADDR_CURRENT = 3'h3;
  localparam logic [2:0] ADDR_VELOCITY = 3'h4;
  localparam logic [2:0] ADDR_FB_HIGH = 3'h5;
  localparam logic [2:0] ADDR_FB_LOW = 3'h6;
  localparam logic [2:0] ADDR_REL_LOCKS = 3'h7;
  localparam int unsigned LOCK_GLOBAL_BIT = 0;
  localparam int unsigned LOCK_TRIM_BIT = 1;
  localparam int unsigned BUS_EN_BIT = 7;
  localparam int unsigned SHAFT_BIT = 4;
  localparam int unsigned SLEEP_BIT = 0;
  localparam int unsigned FAILSAFE_BIT = 1;
  localparam logic [8:0] FB_DISABLED = 9'h100;
  localparam logic [3:0] HOLD_ZERO_CODE = 4'hF;
  localparam logic [3:0] LOWEST_CODE = 4'h0;
  localparam logic [1:0] CMD_PROGRAM = 2'h0;
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_WRITE_SETTINGS = 2'h2;
  localparam int unsigned ZAP_TIME_US = 100;
  localparam int unsigned ZAP_CYC = ZAP_TIME_US * CLK_MHZ;
  localparam int unsigned HOLD_SETTLE_US = 10;
  localparam int unsigned HOLD_SETTLE_CYC = HOLD_SETTLE_US * CLK_MHZ;
  localparam logic [63:0] FACTORY_IMAGE = 64'h0200_0000_0000_8000;
endpackage

// [src/fuse_cell_array.sv]
/*
  Array of one-time-programmable fuse bits, eight bytes wide.
  Assumes factory_load is only used at manufacture; rst_n never touches it.
*/
module fuse_cell_array #(
  parameter logic [63:0] FACTORY = otp_store_pkg::FACTORY_IMAGE
) (
  // Clock and factory image load
  input wire logic mclk,
  input wire logic factory_load,
  // Read port
  input wire logic [2:0] rd_addr,
  output logic [7:0] rd_data,
  // Zap port
  input wire logic zap_en,
  input wire logic [2:0] zap_addr,
  input wire logic [7:0] zap_mask
);
  logic [7:0] mem [otp_store_pkg::NUM_BYTES];

  // Cells survive a device reset, so this array has no reset of its own.
  always_ff @(posedge mclk)
  begin
    if (factory_load)
    begin
      for (int i = 0; i < otp_store_pkg::NUM_BYTES; i++)
      begin
        mem[i] <= FACTORY[i*8 +: 8];
      end
    end
    else if (zap_en)
    begin
      mem[zap_addr] <= mem[zap_addr] | zap_mask;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule

// [src/otp_parameter_store.sv]
/*
  Parameter store: fuse programming and readback, power-up shadowing and
  decoding of the stored settings into working values for the drive.
  Assumes commands arrive from a frame decoder on mclk and that rst_n
  marks a power cycle.
*/
//
// Contract
// - Eight fuse bytes at addresses 0 to 7 hold fixed parameter bits.
// - Fuse bits read zero until programmed; programming sets one permanently.
// - Programming a bit already at one is inhibited.
// - Each program command writes exactly one byte.
// - Programmed global lock refuses all further programming of bytes 0 to 7.
// - Trim lock protects bytes 0 and 1 against programming.
// - Bytes 0, 1 and trim lock hold factory calibration, not settings.
// - New fuse values act only after a power cycle.
// - Read command returns the fuse byte contents for verification.
// - Bus writes override working settings except the address nibble.
// - Node address is four programmed bits plus three hardware pins.
// - Absolute threshold code zero disables detection, else 0.5 V steps.
// - Relative threshold code zero disables detection, else 0.25 V steps.
// - Run current code selects one of sixteen amplitudes.
// - Hold code uses run scale; code 1111 means zero hold.
// - On stop, coil current drops from run to hold setting.
// - Zero hold: go to lowest code, then regulator off, grounds on.
// - Two-bit step resolution selects half to sixteenth stepping.
// - Direction applies to positioning, not continuous velocity mode.
// - Bus loss or error overflow drives the motor to fallback position.
// - Fallback pattern 100 0000 00 disables it; motor holds still.
// - Fallback uses 11 high position bits; two low stored bits zero.
// - After power-up, load working registers from fuses before commands.
module otp_parameter_store #(
  parameter int unsigned ZAP_CYCLES = otp_store_pkg::ZAP_CYC,
  parameter int unsigned SETTLE_CYCLES = otp_store_pkg::HOLD_SETTLE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic fuse_factory_load,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_kind,
  input wire logic [2:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic rsp_refused,
  output logic [7:0] rsp_data,
  output logic store_ready,
  // Address pins and node address
  input wire logic [2:0] hardware_address_pins,
  output logic [6:0] node_address,
  // Motion detection
  output logic [3:0] absolute_motion_threshold,
  output logic abs_detect_enable,
  output logic [3:0] relative_motion_threshold,
  output logic rel_detect_enable,
  // Coil drive
  input wire logic motor_running,
  output logic [3:0] coil_current_code,
  output logic regulator_on,
  output logic low_side_ground,
  // Motion options
  input wire logic continuous_velocity_operation,
  output logic [1:0] step_resolution,
  output logic rotate_ccw,
  output logic sleep_allow,
  output logic failsafe_enable,
  // Fallback positioning
  input wire logic bus_lost,
  input wire logic error_overflow,
  output logic fallback_go,
  output logic fallback_hold,
  output logic [15:0] fallback_position,
  // Calibration trims
  output logic [3:0] clock_trim,
  output logic [3:0] bias_current_trim,
  output logic bus_interface_enable,
  output logic [2:0] thermal_cutoff_trim,
  output logic [3:0] bandgap_trim
);
  typedef enum logic [1:0] {LOAD, IDLE, ZAP} phase_t;

  typedef struct packed {
    phase_t st;
    logic [2:0] idx;
    logic [15:0] cnt;
    logic [7:0][7:0] shadow;
    logic [7:0][7:0] work;
    logic [2:0] hw1;
    logic [2:0] hw2;
    logic ready;
    logic cmd_ready;
    logic rsp_valid;
    logic rsp_refused;
    logic [7:0] rsp_data;
    logic zap_en;
    logic [2:0] zap_addr;
    logic [7:0] zap_mask;
    logic [6:0] node;
    logic abs_en;
    logic rel_en;
    logic [3:0] coil;
    logic reg_on;
    logic gnd;
    logic [15:0] hcnt;
    logic dir;
    logic fb_go;
    logic fb_hold;
    logic [15:0] fb_pos;
  } store_t;

  store_t q;
  store_t d;
  logic [2:0] rd_addr;
  logic [7:0] fuse_byte;
  logic take;
  logic [7:0] fresh;
  logic [8:0] fb_code;

  fuse_cell_array u_fuses (
    .mclk(mclk),
    .factory_load(fuse_factory_load),
    .rd_addr(rd_addr),
    .rd_data(fuse_byte),
    .zap_en(q.zap_en),
    .zap_addr(q.zap_addr),
    .zap_mask(q.zap_mask)
  );

  assign take = cmd_valid && q.cmd_ready;
  assign fb_code = {q.work[otp_store_pkg::ADDR_FB_HIGH][7:5],
                    q.work[otp_store_pkg::ADDR_FB_LOW][7:2]};
  // Bits already at one are masked out of the zap pattern.
  assign fresh = cmd_data & ~fuse_byte;

  always_comb
  begin
    unique case (q.st)
      LOAD: rd_addr = q.idx;
      ZAP: rd_addr = q.zap_addr;
      default: rd_addr = cmd_addr;
    endcase
  end

  always_comb
  begin
    d = q;
    d.rsp_valid = 1'b0;
    d.zap_en = 1'b0;
    d.fb_go = 1'b0;
    d.fb_hold = 1'b0;
    d.hw1 = hardware_address_pins;
    d.hw2 = q.hw1;
    unique case (q.st)
      LOAD:
      begin
        // Shadow and working copies are filled before commands are taken.
        d.shadow[q.idx] = fuse_byte;
        d.work[q.idx] = fuse_byte;
        d.idx = q.idx + 3'h1;
        if (q.idx == 3'h7)
        begin
          d.st = IDLE;
          d.ready = 1'b1;
          d.cmd_ready = 1'b1;
        end
      end
      IDLE:
      begin
        if (take)
        begin
          d.rsp_valid = 1'b1;
          d.rsp_refused = 1'b0;
          d.rsp_data = fuse_byte;
          if (cmd_kind == otp_store_pkg::CMD_PROGRAM)
          begin
            // Locks act as they stood at the last power-up.
            if (q.shadow[otp_store_pkg::ADDR_REL_LOCKS]
                [otp_store_pkg::LOCK_GLOBAL_BIT])
            begin
              d.rsp_refused = 1'b1;
            end
            else if (cmd_addr <= otp_store_pkg::ADDR_TRIM_B &&
                     q.shadow[otp_store_pkg::ADDR_REL_LOCKS]
                     [otp_store_pkg::LOCK_TRIM_BIT])
            begin
              d.rsp_refused = 1'b1;
            end
            else if (fresh != 8'h00)
            begin
              d.rsp_valid = 1'b0;
              d.cmd_ready = 1'b0;
              d.st = ZAP;
              d.zap_addr = cmd_addr;
              d.zap_mask = fresh;
              d.cnt = 16'(ZAP_CYCLES - 1);
            end
          end
          else if (cmd_kind == otp_store_pkg::CMD_WRITE_SETTINGS)
          begin
            if (cmd_addr <= otp_store_pkg::ADDR_TRIM_B)
            begin
              d.rsp_refused = 1'b1;
            end
            else if (cmd_addr == otp_store_pkg::ADDR_THR_NODE)
            begin
              d.work[cmd_addr] = {cmd_data[7:4], q.work[cmd_addr][3:0]};
            end
            else
            begin
              d.work[cmd_addr] = cmd_data;
            end
          end
          else if (cmd_kind != otp_store_pkg::CMD_READ)
          begin
            d.rsp_refused = 1'b1;
          end
        end
      end
      ZAP:
      begin
        // The zap pulse lasts one cycle after the full programming time, one byte only.
        d.cnt = q.cnt - 16'h1;
        if (q.cnt == 16'h0)
        begin
          d.zap_en = 1'b1;
          d.rsp_valid = 1'b1;
          d.rsp_refused = 1'b0;
          d.rsp_data = fuse_byte | q.zap_mask;
          d.st = IDLE;
          d.cmd_ready = 1'b1;
        end
      end
    endcase

    d.node = {q.shadow[otp_store_pkg::ADDR_THR_NODE][3:0], q.hw2};
    d.abs_en = q.work[otp_store_pkg::ADDR_THR_NODE][7:4] != 4'h0;
    d.rel_en = q.work[otp_store_pkg::ADDR_REL_LOCKS][7:4] != 4'h0;

    d.reg_on = 1'b1;
    d.gnd = 1'b0;
    d.hcnt = 16'h0;
    if (motor_running)
    begin
      d.coil = q.work[otp_store_pkg::ADDR_CURRENT][7:4];
    end
    else if (q.work[otp_store_pkg::ADDR_CURRENT][3:0] !=
             otp_store_pkg::HOLD_ZERO_CODE)
    begin
      d.coil = q.work[otp_store_pkg::ADDR_CURRENT][3:0];
    end
    else if (q.hcnt < 16'(SETTLE_CYCLES))
    begin
      d.coil = otp_store_pkg::LOWEST_CODE;
      d.hcnt = q.hcnt + 16'h1;
    end
    else
    begin
      d.coil = otp_store_pkg::LOWEST_CODE;
      d.reg_on = 1'b0;
      d.gnd = 1'b1;
      d.hcnt = q.hcnt;
    end

    if (!continuous_velocity_operation)
    begin
      d.dir = q.work[otp_store_pkg::ADDR_FB_HIGH]
              [otp_store_pkg::SHAFT_BIT];
    end

    d.fb_pos = {fb_code, 2'b00, 5'h00};
    if (q.ready && (bus_lost || error_overflow))
    begin
      d.fb_hold = fb_code == otp_store_pkg::FB_DISABLED;
      d.fb_go = fb_code != otp_store_pkg::FB_DISABLED;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= LOAD;
    end
    else
    begin
      q <= d;
    end
  end

  assign cmd_ready = q.cmd_ready;
  assign rsp_valid = q.rsp_valid;
  assign rsp_refused = q.rsp_refused;
  assign rsp_data = q.rsp_data;
  assign store_ready = q.ready;
  assign node_address = q.node;
  assign absolute_motion_threshold = q.work[otp_store_pkg::ADDR_THR_NODE][7:4];
  assign abs_detect_enable = q.abs_en;
  assign relative_motion_threshold = q.work[otp_store_pkg::ADDR_REL_LOCKS][7:4];
  assign rel_detect_enable = q.rel_en;
  assign coil_current_code = q.coil;
  assign regulator_on = q.reg_on;
  assign low_side_ground = q.gnd;
  assign step_resolution = q.work[otp_store_pkg::ADDR_REL_LOCKS][3:2];
  assign rotate_ccw = q.dir;
  assign sleep_allow = q.work[otp_store_pkg::ADDR_FB_LOW]
                       [otp_store_pkg::SLEEP_BIT];
  assign failsafe_enable = q.work[otp_store_pkg::ADDR_FB_LOW]
                           [otp_store_pkg::FAILSAFE_BIT];
  assign fallback_go = q.fb_go;
  assign fallback_hold = q.fb_hold;
  assign fallback_position = q.fb_pos;
  assign clock_trim = q.shadow[otp_store_pkg::ADDR_TRIM_A][7:4];
  assign bias_current_trim = q.shadow[otp_store_pkg::ADDR_TRIM_A][3:0];
  assign bus_interface_enable = q.shadow[otp_store_pkg::ADDR_TRIM_B]
                                [otp_store_pkg::BUS_EN_BIT];
  assign thermal_cutoff_trim = q.shadow[otp_store_pkg::ADDR_TRIM_B][6:4];
  assign bandgap_trim = q.shadow[otp_store_pkg::ADDR_TRIM_B][3:0];

  sequence read_taken_s;
    take && cmd_kind == otp_store_pkg::CMD_READ;
  endsequence
  sequence read_answer_s;
    rsp_valid && !rsp_refused;
  endsequence

  zap_new_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    q.zap_en |-> (q.zap_mask & $past(fuse_byte)) == 8'h00)
    else $error("zap hit a bit already at one");
  global_lock_a: assert property (@(posedge mclk) disable iff (!rst_n)
    q.zap_en |-> !q.shadow[otp_store_pkg::ADDR_REL_LOCKS][0])
    else $error("zap despite global lock");
  trim_lock_a: assert property (@(posedge mclk) disable iff (!rst_n)
    q.zap_en && q.zap_addr <= otp_store_pkg::ADDR_TRIM_B |->
      !q.shadow[otp_store_pkg::ADDR_REL_LOCKS][otp_store_pkg::LOCK_TRIM_BIT])
    else $error("trim bytes zapped despite trim lock");
  single_zap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    q.zap_en |-> cmd_ready ##1 !q.zap_en)
    else $error("zap pulse longer than one cycle");
  load_first_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(store_ready) |-> $past(q.st == LOAD && q.idx == 3'h7))
    else $error("ready before all bytes loaded");
  read_back_a: assert property (@(posedge mclk) disable iff (!rst_n)
    read_taken_s |=> read_answer_s ##0 rsp_data == $past(fuse_byte))
    else $error("read answer wrong");
  node_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    store_ready ##1 store_ready |-> node_address ==
      {$past(q.shadow[otp_store_pkg::ADDR_THR_NODE][3:0]), $past(q.hw2)})
    else $error("node address mismatch");
  zero_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(low_side_ground) |-> $past(q.reg_on && q.coil == 4'h0))
    else $error("grounded without lowest current first");
  run_current_a: assert property (@(posedge mclk) disable iff (!rst_n)
    motor_running ##1 motor_running |-> coil_current_code ==
      $past(q.work[otp_store_pkg::ADDR_CURRENT][7:4]))
    else $error("run current not applied");
  fb_disabled_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fallback_go |-> $past(fb_code) != otp_store_pkg::FB_DISABLED)
    else $error("fallback move while disabled");
  fb_low_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fallback_position[6:0] == 7'h00)
    else $error("fallback low bits not zero");
endmodule

// [dv/param_master.sv]
/*
  Behavioural model of the serial-bus master that issues parameter
  commands to the store, one byte per request.
  Assumes the store answers every accepted request with rsp_valid.
*/
module param_master (
  // Clock
  input wire logic mclk,
  // Request side
  output logic cmd_valid,
  output logic [1:0] cmd_kind,
  output logic [2:0] cmd_addr,
  output logic [7:0] cmd_data,
  // Answer side
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic rsp_refused,
  input wire logic [7:0] rsp_data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    cmd_valid = 1'b0;
    cmd_kind = 2'h0;
    cmd_addr = 3'h0;
    cmd_data = 8'h00;
  end

  // Idle lines show the inverse of the last request so stale values fail.
  task automatic send(input logic [1:0] kind, input logic [2:0] addr,
    input logic [7:0] data, output logic [7:0] rdata,
    output logic refused, output logic timed_out);
    int n;
    timed_out = 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_kind <= kind;
    cmd_addr <= addr;
    cmd_data <= data;
    for (n = 0; n < 50; n++)
    begin
      @(negedge mclk);
      if (cmd_ready === 1'b1)
        break;
    end
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_kind <= ~kind;
    cmd_addr <= ~addr;
    cmd_data <= ~data;
    for (n = 0; n < 50; n++)
    begin
      @(negedge mclk);
      if (rsp_valid === 1'b1)
      begin
        timed_out = 1'b0;
        break;
      end
    end
    rdata = rsp_data;
    refused = rsp_refused;
  endtask
endmodule

// [dv/tb.sv]
/*
  Self-checking bench of the parameter store: programs, reads and writes
  bytes through the command master and checks the decoded settings.
  Assumes the package factory image and shortened zap and settle counts.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned SETTLE_N = 6;
  localparam logic [1:0] PG = otp_store_pkg::CMD_PROGRAM;
  localparam logic [1:0] RD = otp_store_pkg::CMD_READ;
  localparam logic [1:0] WR = otp_store_pkg::CMD_WRITE_SETTINGS;
  localparam logic [63:0] IMG = otp_store_pkg::FACTORY_IMAGE;
  logic mclk, rst_n, fuse_factory_load, cmd_valid, cmd_ready, rsp_valid;
  logic rsp_refused, store_ready, abs_detect_enable, rel_detect_enable;
  logic motor_running, regulator_on, low_side_ground, rotate_ccw;
  logic continuous_velocity_operation, sleep_allow, failsafe_enable;
  logic bus_lost, error_overflow, fallback_go, fallback_hold;
  logic bus_interface_enable;
  logic [1:0] cmd_kind, step_resolution;
  logic [2:0] cmd_addr, hardware_address_pins, thermal_cutoff_trim;
  logic [7:0] cmd_data, rsp_data;
  logic [6:0] node_address;
  logic [3:0] absolute_motion_threshold, relative_motion_threshold;
  logic [3:0] coil_current_code, clock_trim, bias_current_trim, bandgap_trim;
  logic [15:0] fallback_position;
  int err_count = 0;
  int compares = 0;

  otp_parameter_store #(.ZAP_CYCLES(4), .SETTLE_CYCLES(SETTLE_N)) dut_u (
    .mclk, .rst_n, .fuse_factory_load, .cmd_valid, .cmd_ready, .cmd_kind,
    .cmd_addr, .cmd_data, .rsp_valid, .rsp_refused, .rsp_data, .store_ready,
    .hardware_address_pins, .node_address, .absolute_motion_threshold,
    .abs_detect_enable, .relative_motion_threshold, .rel_detect_enable,
    .motor_running, .coil_current_code, .regulator_on, .low_side_ground,
    .continuous_velocity_operation, .step_resolution, .rotate_ccw,
    .sleep_allow, .failsafe_enable, .bus_lost, .error_overflow, .fallback_go,
    .fallback_hold, .fallback_position, .clock_trim, .bias_current_trim,
    .bus_interface_enable, .thermal_cutoff_trim, .bandgap_trim);

  param_master master_u (.mclk, .cmd_valid, .cmd_kind, .cmd_addr, .cmd_data,
    .cmd_ready, .rsp_valid, .rsp_refused, .rsp_data);

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic print_verdict();
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Write answers carry the addressed fuse byte, not the written value, so only reads and programs compare it.
  task automatic cmd(input logic [1:0] k, input logic [2:0] a,
    input logic [7:0] d, input logic [7:0] exp_d, input logic exp_r);
    logic [7:0] rd;
    logic rf;
    logic to;
    master_u.send(k, a, d, rd, rf, to);
    if (to !== 1'b0)
    begin
      err_count++;
      print_verdict();
    end
    check(16'(rf), 16'(exp_r));
    if (exp_r == 1'b0 && k != WR)
      check(16'(rd), 16'(exp_d));
  endtask

  task automatic power_cycle();
    int n;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    fuse_factory_load <= 1'b0;
    rst_n <= 1'b1;
    @(negedge mclk);
    check(16'({store_ready, cmd_ready}), 16'h0000);
    for (n = 0; n < 40 && store_ready !== 1'b1; n++)
      @(negedge mclk);
    if (store_ready !== 1'b1)
    begin
      err_count++;
      print_verdict();
    end
  endtask

  task automatic pulse_fault(input logic lost);
    @(posedge mclk);
    bus_lost <= lost;
    error_overflow <= ~lost;
    @(posedge mclk);
    bus_lost <= 1'b0;
    error_overflow <= 1'b0;
    @(negedge mclk);
  endtask

  initial
  begin
    {rst_n, motor_running, continuous_velocity_operation} = 3'h0;
    {bus_lost, error_overflow} = 2'h0;
    fuse_factory_load = 1'b1;
    hardware_address_pins = 3'h5;
    power_cycle();
    for (int i = 0; i < 8; i++)
      cmd(RD, 3'(i), 8'h00, IMG[i*8 +: 8], 1'b0);
    check(16'({clock_trim, bias_current_trim}), 16'(IMG[7:0]));
    check(16'({bus_interface_enable, thermal_cutoff_trim, bandgap_trim}),
      16'(IMG[15:8]));
    cmd(PG, 3'h0, 8'h01, 8'h00, 1'b1);
    cmd(PG, 3'h1, 8'h01, 8'h00, 1'b1);
    cmd(PG, 3'h2, 8'h34, 8'h34, 1'b0);
    cmd(PG, 3'h2, 8'h08, 8'h3C, 1'b0);
    cmd(PG, 3'h2, 8'h3C, 8'h3C, 1'b0);
    cmd(RD, 3'h2, 8'h00, 8'h3C, 1'b0);
    cmd(RD, 3'h3, 8'h00, 8'h00, 1'b0);
    check(16'({absolute_motion_threshold, node_address}), 16'h0005);
    power_cycle();
    check(16'(node_address), 16'h0065);
    check(16'({abs_detect_enable, absolute_motion_threshold}), 16'h0013);
    cmd(WR, 3'h2, 8'h0A, 8'h00, 1'b0);
    tick(2);
    check(16'({abs_detect_enable, node_address}), 16'h0065);
    cmd(WR, 3'h0, 8'hFF, 8'h00, 1'b1);
    cmd(2'h3, 3'h4, 8'h00, 8'h00, 1'b1);
    for (int s = 0; s < 4; s++)
    begin
      cmd(WR, 3'h7, {4'(s), 2'(s), 2'b00}, 8'h00, 1'b0);
      tick(2);
      check(16'(step_resolution), 16'(s));
      check(16'({rel_detect_enable, relative_motion_threshold}),
        16'({s != 0, 4'(s)}));
    end
    @(posedge mclk);
    motor_running <= 1'b1;
    cmd(WR, 3'h3, 8'hA6, 8'h00, 1'b0);
    tick(3);
    check(16'(coil_current_code), 16'h000A);
    @(posedge mclk);
    motor_running <= 1'b0;
    tick(3);
    check(16'({regulator_on, coil_current_code}), 16'h0016);
    @(posedge mclk);
    motor_running <= 1'b1;
    cmd(WR, 3'h3, 8'hAF, 8'h00, 1'b0);
    tick(2);
    @(posedge mclk);
    motor_running <= 1'b0;
    tick(3);
    check(16'({low_side_ground, regulator_on, coil_current_code}),
      16'h0010);
    tick(SETTLE_N + 4);
    check(16'({low_side_ground, regulator_on}), 16'h0002);
    cmd(WR, 3'h5, 8'h10, 8'h00, 1'b0);
    tick(2);
    check(16'(rotate_ccw), 16'h0001);
    @(posedge mclk);
    continuous_velocity_operation <= 1'b1;
    cmd(WR, 3'h5, 8'h00, 8'h00, 1'b0);
    tick(2);
    check(16'(rotate_ccw), 16'h0001);
    @(posedge mclk);
    continuous_velocity_operation <= 1'b0;
    tick(3);
    check(16'(rotate_ccw), 16'h0000);
    cmd(WR, 3'h5, 8'hA0, 8'h00, 1'b0);
    cmd(WR, 3'h6, 8'hFC, 8'h00, 1'b0);
    tick(2);
    check(fallback_position, 16'hBF80);
    pulse_fault(1'b1);
    check(16'({fallback_go, fallback_hold}), 16'h0002);
    cmd(WR, 3'h5, 8'h80, 8'h00, 1'b0);
    cmd(WR, 3'h6, 8'h03, 8'h00, 1'b0);
    tick(2);
    check(16'({sleep_allow, failsafe_enable}), 16'h0003);
    pulse_fault(1'b0);
    check(16'({fallback_go, fallback_hold}), 16'h0001);
    cmd(PG, 3'h7, 8'h01, 8'h03, 1'b0);
    cmd(PG, 3'h4, 8'h11, 8'h11, 1'b0);
    power_cycle();
    check(16'({abs_detect_enable, absolute_motion_threshold}), 16'h0013);
    cmd(PG, 3'h4, 8'h22, 8'h00, 1'b1);
    cmd(PG, 3'h6, 8'h01, 8'h00, 1'b1);
    cmd(RD, 3'h4, 8'h00, 8'h11, 1'b0);
    print_verdict();
  end
endmodule
